// [irq_gate.sv]
// Pairs status with enable bits and applies the master gate
`timescale 1ns/1ns
`include "usb_irq_cfg.svh"
module irq_gate (
  irq_gate_if.gate gate_io
);

  logic [`IRQ_BIT_MASTER-1:0] pair_hit;

  // One AND per bit position; the master bit itself is no event
  genvar i;
  generate
    for (i = 0; i < `IRQ_BIT_MASTER; i++) begin : g_pair
      assign pair_hit[i] = gate_io.status[i] & gate_io.enable[i];
    end
  endgenerate

  // Any selected event, passed only while the master gate is open
  assign gate_io.request = gate_io.enable[`IRQ_BIT_MASTER] & (|pair_hit);

endmodule : irq_gate

// [irq_gate_if.sv]
// Carrier between the register file and the request gate
`timescale 1ns/1ns
interface irq_gate_if;
  usb_irq_pkg::word_t status;
  usb_irq_pkg::word_t enable;
  logic request;

  modport regs (output status, output enable, input request);
  modport gate (input status, input enable, output request);
endinterface : irq_gate_if

// [irq_props.sv]
// Port assertions of the interrupt enable block
`timescale 1ns/1ns
module irq_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic schedule_overrun_i,
  input wire logic irq_o,
  input wire logic [31:0] enable_mask_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Overrun bit and master gate both enabled
  sequence s_armed;
    enable_mask_o[31] && enable_mask_o[0];
  endsequence
  sequence s_overrun;
    schedule_overrun_i ##0 s_armed;
  endsequence
  a_event_raises_irq: assert property (s_overrun ##1 s_armed |=> irq_o)
    else $error("irq missing after event");
  a_master_blocks: assert property (!enable_mask_o[31] |=> !irq_o)
    else $error("irq without master gate");
  a_enable_sets: assert property (reg_wr_i && reg_addr_i == 8'h10 |=>
    enable_mask_o == (($past(enable_mask_o) | $past(reg_wdata_i)) & 32'hC000007F)) else $error("enable write");
  a_disable_clears: assert property (reg_wr_i && reg_addr_i == 8'h14 |=>
    enable_mask_o == ($past(enable_mask_o) & ~$past(reg_wdata_i))) else $error("disable write");
  a_enable_holds: assert property (!reg_wr_i |=> $stable(enable_mask_o))
    else $error("enable changed");
  a_read_answers: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("no read valid");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("stray read valid");
  a_read_mask: assert property (reg_rd_i && reg_addr_i[7:3] == 5'h02 && reg_addr_i[1:0] == 2'h0 |=>
    reg_rdata_o == $past(enable_mask_o)) else $error("mask read");
endmodule : irq_props
bind usb_irq_enable irq_props irq_props_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .schedule_overrun_i(schedule_overrun_i), .irq_o(irq_o),
  .enable_mask_o(enable_mask_o));

// [irq_sink.sv]
// Host-side receiver of the interrupt request line
`timescale 1ns/1ns
module irq_sink (
  input wire logic clk_i,
  input wire logic irq_i,
  output int rise_cnt_o
);
  logic last_q = 1'b0;
  int cnt_q = 0;
  // A level-triggered host sees one new request per rising edge
  always @(posedge clk_i) begin
    last_q <= irq_i;
    if (irq_i && !last_q) begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign rise_cnt_o = cnt_q;
endmodule : irq_sink

// [tb_top.sv]
// Self-checking bench for the interrupt enable block
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; \
  if ((g) !== (e)) begin error_cnt++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h00000000;
  logic [31:0] reg_rdata_o, enable_mask_o, d, de;
  logic [31:0] en = 32'h00000000;
  logic [31:0] exp_q[$];
  logic reg_rvalid_o, irq_o;
  logic [7:0] ev = 8'h00;
  int error_cnt = 0;
  int checks_done = 0;
  int rises;
  integer seed = 89;
  int pos[8] = '{30, 6, 5, 4, 3, 2, 1, 0};
  initial forever #20 clk_i = ~clk_i;
  usb_irq_enable usb_irq_enable_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .ownership_change_i(ev[0]), .root_port_change_i(ev[1]), .frame_count_overflow_i(ev[2]),
    .fatal_system_error_i(ev[3]), .resume_seen_i(ev[4]), .frame_start_i(ev[5]),
    .done_queue_writeback_i(ev[6]), .schedule_overrun_i(ev[7]), .irq_o(irq_o), .enable_mask_o(enable_mask_o));
  irq_sink irq_sink_inst (.clk_i(clk_i), .irq_i(irq_o), .rise_cnt_o(rises));
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(negedge clk_i);
    reg_wr_i = w;
    reg_rd_i = !w;
    reg_addr_i = a;
    reg_wdata_i = v;
    if (!w) exp_q.push_back(v);
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
  endtask : acc
  // Event held one cycle; irq is looked at two edges later
  task automatic pulse(input int i);
    @(negedge clk_i);
    ev = 8'h01 << i;
    @(negedge clk_i);
    ev = 8'h00;
    @(negedge clk_i);
  endtask : pulse
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // Read results are taken in issue order as they appear
  always @(negedge clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      de = exp_q.pop_front();
      `CHK("rdata", de, reg_rdata_o)
    end
  end
  initial begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    acc(0, 8'h10, 32'h00000000);
    acc(0, 8'h0C, 32'h00000000);
    for (int i = 0; i < 8; i++) begin
      en = en | 32'h80000000 | (32'h00000001 << pos[i]);
      acc(1, 8'h10, 32'h80000000 | (32'h00000001 << pos[i]));
      acc(0, 8'h14, en);
      pulse(i);
      `CHK("irq", 1'b1, irq_o)
      acc(1, 8'h0C, 32'h00000001 << pos[i]);
      @(negedge clk_i);
      `CHK("irq", 1'b0, irq_o)
    end
    acc(1, 8'h14, 32'hC000007F);
    acc(1, 8'h10, 32'h80000001);
    pulse(6);
    `CHK("irq", 1'b0, irq_o)
    acc(1, 8'h0C, 32'h00000002);
    acc(1, 8'h14, 32'h80000000);
    pulse(7);
    `CHK("irq", 1'b0, irq_o)
    acc(1, 8'h10, 32'h80000000);
    @(negedge clk_i);
    `CHK("irq", 1'b1, irq_o)
    acc(1, 8'h0C, 32'h00000001);
    en = 32'h80000001;
    // Random masks keep reserved bits zero, as software must
    for (int k = 0; k < 6; k++) begin
      d = $random(seed) & 32'hC000007F;
      acc(1, 8'h10, d);
      en = en | d;
      d = $random(seed) & 32'hC000007F;
      acc(1, 8'h14, d);
      en = en & ~d;
      acc(0, 8'h10, en);
      `CHK("mask", en, enable_mask_o)
    end
    acc(0, 8'h40, 32'h00000000);
    for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(negedge clk_i);
    if (exp_q.size() > 0) error_cnt++;
    `CHK("rises", 9, rises)
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    test_done();
  end
endmodule : tb_top

// [usb_irq_cfg.svh]
// Offsets, field positions and reset values of the interrupt enable block
`ifndef USB_IRQ_CFG_SVH
`define USB_IRQ_CFG_SVH

// Register offsets within the operational register space
`define IRQ_OFS_STATUS 8'h0C
`define IRQ_OFS_ENABLE 8'h10
`define IRQ_OFS_DISABLE 8'h14

// Field positions shared by status, enable and disable registers; the master bit 31 exists in enable and disable only
`define IRQ_BIT_MASTER 31
`define IRQ_BIT_OWNERSHIP 30
`define IRQ_BIT_ROOT_PORT 6
`define IRQ_BIT_FRAME_OVF 5
`define IRQ_BIT_FATAL 4
`define IRQ_BIT_RESUME 3
`define IRQ_BIT_FRAME_START 2
`define IRQ_BIT_DONE_WB 1
`define IRQ_BIT_OVERRUN 0

// Implemented bits; reserved positions store nothing and read zero
`define IRQ_ENABLE_IMPL 32'hC000007F
`define IRQ_STATUS_IMPL 32'h4000007F

// Reset values
`define IRQ_ENABLE_RESET 32'h00000000
`define IRQ_STATUS_RESET 32'h00000000
`define IRQ_RDATA_RESET 32'h00000000

`endif

// [usb_irq_enable.sv]
// Interrupt status, enable mask and request line of a USB host function
`timescale 1ns/1ns
`include "usb_irq_cfg.svh"
module usb_irq_enable (
  input wire logic clk_i,
  input wire logic rst_i,
  // Register access port
  // Same clock as the block, one-cycle strobes
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire usb_irq_pkg::reg_addr_t reg_addr_i,
  input wire usb_irq_pkg::word_t reg_wdata_i,
  output usb_irq_pkg::word_t reg_rdata_o,
  output logic reg_rvalid_o,
  // Event pulses from the neighbouring units
  // Each is a one-cycle pulse on this clock
  input wire logic ownership_change_i,
  input wire logic root_port_change_i,
  input wire logic frame_count_overflow_i,
  input wire logic fatal_system_error_i,
  input wire logic resume_seen_i,
  input wire logic frame_start_i,
  input wire logic done_queue_writeback_i,
  input wire logic schedule_overrun_i,
  // Request to the host bus
  // Level, active high
  output logic irq_o,
  output usb_irq_pkg::word_t enable_mask_o
);

  // Event status; reserved positions never hold a bit
  usb_irq_pkg::word_t status_q;
  usb_irq_pkg::word_t status_d;

  // Enable mask with the master gate in the top bit
  usb_irq_pkg::word_t enable_q;
  usb_irq_pkg::word_t enable_d;

  // Read return path
  usb_irq_pkg::word_t rdata_q;
  usb_irq_pkg::word_t rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // Registered request line
  logic irq_q;
  logic irq_d;

  // Decoded access and per-register bit strobes
  usb_irq_pkg::reg_sel_e sel;
  usb_irq_pkg::word_t event_set;
  usb_irq_pkg::word_t status_clr;
  usb_irq_pkg::word_t enable_set;
  usb_irq_pkg::word_t enable_clr;

  // Register map, byte offsets on the access port:
  //   0x0C event status, a written one clears the bit
  //   0x10 enable mask, a written one sets the bit
  //   0x14 disable alias, a written one clears the bit, reads the mask
  // Other offsets read zero with a valid strobe and ignore writes,
  // so a stray access never stalls the host.

  // Carrier to the request gate
  irq_gate_if gate_bus ();

  // Request gate sees the live register contents
  // Its result is registered below, never used raw at the pin
  irq_gate u_gate (
    .gate_io(gate_bus.gate)
  );

  assign gate_bus.status = status_q;
  assign gate_bus.enable = enable_q;

  // Address decode shared by reads and writes
  // Strobes are applied where each register is built, not here
  always_comb begin
    unique case (reg_addr_i)
      `IRQ_OFS_STATUS: sel = usb_irq_pkg::SEL_STATUS;
      `IRQ_OFS_ENABLE: sel = usb_irq_pkg::SEL_ENABLE;
      `IRQ_OFS_DISABLE: sel = usb_irq_pkg::SEL_DISABLE;
      default: sel = usb_irq_pkg::SEL_NONE;
    endcase
  end

  // Event pulses placed at their status bit positions
  // Sources sit on this clock, so no synchroniser is needed
  // Bits 29..7 stay zero
  always_comb begin
    event_set = 32'h00000000;
    event_set[`IRQ_BIT_OWNERSHIP] = ownership_change_i;
    event_set[`IRQ_BIT_ROOT_PORT] = root_port_change_i;
    event_set[`IRQ_BIT_FRAME_OVF] = frame_count_overflow_i;
    event_set[`IRQ_BIT_FATAL] = fatal_system_error_i;
    event_set[`IRQ_BIT_RESUME] = resume_seen_i;
    event_set[`IRQ_BIT_FRAME_START] = frame_start_i;
    event_set[`IRQ_BIT_DONE_WB] = done_queue_writeback_i;
    event_set[`IRQ_BIT_OVERRUN] = schedule_overrun_i;
  end

  // Write strobes per register; zeros in the data touch nothing
  // Offsets are exclusive, so one write raises at most one strobe
  always_comb begin
    status_clr = 32'h00000000;
    enable_set = 32'h00000000;
    enable_clr = 32'h00000000;
    if (reg_wr_i) begin
      if (sel == usb_irq_pkg::SEL_STATUS) begin
        status_clr = reg_wdata_i;
      end
      if (sel == usb_irq_pkg::SEL_ENABLE) begin
        enable_set = reg_wdata_i;
      end
      if (sel == usb_irq_pkg::SEL_DISABLE) begin
        enable_clr = reg_wdata_i;
      end
    end
  end

  // Status bits: an event in the clearing cycle survives, so set wins
  // Software cannot set a status bit; only the event inputs can
  always_comb begin
    status_d = ((status_q & ~status_clr) | event_set) & `IRQ_STATUS_IMPL;
  end

  // Status register
  // Synchronous reset; all state clears to zero, so the block starts masked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= `IRQ_STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Enable mask: set on enable writes, clear on disable writes.
  // Only bits 31, 30 and 6..0 are stored, so a careless reserved write
  // from software cannot open a phantom source.
  // Set and clear never meet, as they sit at different offsets.
  always_comb begin
    enable_d = ((enable_q & ~enable_clr) | enable_set) & `IRQ_ENABLE_IMPL;
  end

  // Enable register; master gate, ownership and the seven USB events
  // Bit 30 stays visible on enable_mask_o for the management interrupt path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= `IRQ_ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  // Read mux; enable and disable offsets both return the enable mask
  // A write in the same cycle is not yet visible, so the old value returns
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd_i;
    if (reg_rd_i) begin
      unique case (sel)
        usb_irq_pkg::SEL_STATUS: rdata_d = status_q;
        usb_irq_pkg::SEL_ENABLE: rdata_d = enable_q;
        usb_irq_pkg::SEL_DISABLE: rdata_d = enable_q;
        usb_irq_pkg::SEL_NONE: rdata_d = 32'h00000000;
      endcase
    end
  end

  // Read data is held until the next read
  // Clearing on reset keeps a read before any write deterministic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= `IRQ_RDATA_RESET;
      rvalid_q <= 1'h0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Timing at the pins:
  //   edge 1 an event pulse or a register write lands in its register
  //   edge 2 irq_o follows the new gate result
  // A level-sensitive host does not miss a request for the extra edge,
  // and the request drops one edge after the last source goes away.

  // Registered level request; costs one clock but gives a glitch-free line
  always_comb begin
    irq_d = gate_bus.request;
  end

  // Request flop; the line stays low through reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'h0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Outputs come straight from flops
  assign irq_o = irq_q;
  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign enable_mask_o = enable_q; // Lets the SMI path see the ownership enable

endmodule : usb_irq_enable

// [usb_irq_pkg.sv]
// Types shared by the interrupt enable block
package usb_irq_pkg;

  typedef logic [31:0] word_t;
  typedef logic [7:0] reg_addr_t;

  // Register selected by the current access, Gray coded
  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_STATUS = 2'h1,
    SEL_ENABLE = 2'h3,
    SEL_DISABLE = 2'h2
  } reg_sel_e;

endpackage : usb_irq_pkg
